// *** bwps_regs.vh ***
// Register map, field positions and timing constants for boot and wake pin signaling
// Notes on behaviour
// - Boot disable clear: raise boot pulse on the pin the routing bit selects.
// - Boot interrupt is a pulse whose active level follows the polarity setting.
// - Boot disable set: no boot pulse on either interrupt pin.
// - Strap low: pulse the selected pin for the short boot time after boot.
// - Strap high: ignore disable, force second pin, drive low for long time.
// - Boot disable survives soft reset; cleared by power loss or deep power-down.
// - Awake output enable clear: active power state shown on no pin.
// - Awake enabled and state 01b: hold selected pin at active level.
// - Leaving active state: selected awake pin goes to inverse level.
// - Strap high: second pin carries only the boot pulse, others ignored.
// - Boot routing bit: clear selects first pin, set selects second pin.
// - Awake routing bit: clear selects first pin, set selects second pin.
`ifndef BWPS_REGS_VH
`define BWPS_REGS_VH
`define BWPS_ADDR_W 8
`define BWPS_ADDR_INT_EN 8'h20
`define BWPS_ADDR_PIN_SEL 8'h21
`define BWPS_ADDR_CTRL 8'h22
`define BWPS_ADDR_STATUS 8'h23
`define BWPS_BIT_AWAKE_EN 0
`define BWPS_BIT_BOOT_EVENT_DISABLE 1
`define BWPS_BIT_AWAKE_ROUTE 0
`define BWPS_BIT_BOOT_ROUTE 1
`define BWPS_BIT_POL 0
`define BWPS_BIT_SOFT_RST 1
`define BWPS_BIT_DEEP_PD 2
`define BWPS_BIT_BOOT_DONE 3
`define BWPS_INT_EN_RST 8'h00
`define BWPS_INT_EN_RST_STRAP 8'h20
`define BWPS_PIN_SEL_RST 8'h00
`define BWPS_BOOT_EVENT_DISABLE_MASK 8'h02
`define BWPS_US_PER_MS 1000
`define BWPS_STATE_AWAKE 2'h1
`define BWPS_CLK_MHZ 100
`define BWPS_SHORT_US 10
`define BWPS_LONG_MS 5
`endif

// *** bwps_pulse_timer.v ***
// Down counter that stretches a start strobe into a pulse of fixed length
`timescale 1ns/1ps
`default_nettype none
module bwps_pulse_timer #(
  parameter CNT_W = 20
) (
  // Clock and control
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire start_i,
  input wire abort_i,
  input wire [CNT_W-1:0] len_i,
  // Status
  output reg busy_o
);
  reg [CNT_W-1:0] cnt;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt <= {CNT_W{1'b0}};
      busy_o <= 1'b0;
    end else if (ce_i) begin
      if (abort_i) begin
        cnt <= {CNT_W{1'b0}};
        busy_o <= 1'b0;
      end else if (start_i) begin
        cnt <= len_i - {{(CNT_W-1){1'b0}}, 1'b1};
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt == {CNT_W{1'b0}}) begin
          busy_o <= 1'b0;
        end else begin
          cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // bwps_pulse_timer
`default_nettype wire

// *** bwps_top.v ***
// Boot-complete pulse and awake-state level drivers for two interrupt pins
`timescale 1ns/1ps
`default_nettype none
`include "bwps_regs.vh"
module bwps_top #(
  parameter CNT_W = 20,
  parameter SHORT_CYC = `BWPS_SHORT_US * `BWPS_CLK_MHZ,
  parameter LONG_CYC = `BWPS_LONG_MS * `BWPS_US_PER_MS * `BWPS_CLK_MHZ
) (
  // Clock, reset, enable
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // Pins and state from the rest of the device
  input wire boot_strap_select_i,
  input wire [1:0] sys_state_i,
  input wire other_irq1_i,
  input wire other_irq2_i,
  // Register port
  input wire [`BWPS_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Interrupt pins; only the second pin is open-drain, when strap is high
  output reg first_interrupt_pin_o,
  output reg first_interrupt_pin_oe_o,
  output reg second_interrupt_pin_o,
  output reg second_interrupt_pin_oe_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_PULSE = 3'b010;
  localparam ST_DONE = 3'b100;

  // Strap synchroniser; meta read only by the second stage
  reg strap_meta;
  reg strap_sync;
  reg strap;
  reg boot_req;
  reg [7:0] int_en;
  reg [7:0] pin_sel;
  reg interrupt_polarity;
  reg [2:0] state;
  reg [2:0] next_state;
  reg next_first;
  reg next_second;
  reg next_first_oe;
  reg next_second_oe;
  wire busy;
  wire soft_rst;
  wire deep_pd;
  wire boot_done;
  wire boot_event_disable;
  wire awake_en;
  wire boot_active;
  wire boot_route;
  wire awake_route;
  wire awake_level;
  wire pulse_lvl;
  wire [CNT_W-1:0] pulse_len;

  function [7:0] rd_mux;
    input [`BWPS_ADDR_W-1:0] a;
    input [7:0] ie;
    input [7:0] ps;
    input [7:0] ct;
    input [7:0] st;
    begin
      case (a)
        `BWPS_ADDR_INT_EN: rd_mux = ie;
        `BWPS_ADDR_PIN_SEL: rd_mux = ps;
        `BWPS_ADDR_CTRL: rd_mux = ct;
        `BWPS_ADDR_STATUS: rd_mux = st;
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  assign soft_rst = wr_i && (addr_i == `BWPS_ADDR_CTRL) && wdata_i[`BWPS_BIT_SOFT_RST];
  assign deep_pd = wr_i && (addr_i == `BWPS_ADDR_CTRL) && wdata_i[`BWPS_BIT_DEEP_PD];
  assign boot_done = wr_i && (addr_i == `BWPS_ADDR_CTRL) && wdata_i[`BWPS_BIT_BOOT_DONE];
  assign boot_event_disable = int_en[`BWPS_BIT_BOOT_EVENT_DISABLE] && !strap;
  assign awake_en = int_en[`BWPS_BIT_AWAKE_EN];
  assign boot_route = strap | pin_sel[`BWPS_BIT_BOOT_ROUTE];
  assign awake_route = pin_sel[`BWPS_BIT_AWAKE_ROUTE];
  assign boot_active = (state == ST_PULSE) && busy;
  assign awake_level = (sys_state_i == `BWPS_STATE_AWAKE);
  assign pulse_lvl = strap ? 1'b0 : interrupt_polarity;
  assign pulse_len = strap ? LONG_CYC[CNT_W-1:0] : SHORT_CYC[CNT_W-1:0];

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else if (ce_i) begin
      strap_meta <= boot_strap_select_i;
      strap_sync <= strap_meta;
    end
  end

  // Registers; boot disable kept across soft reset
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      int_en <= `BWPS_INT_EN_RST;
      pin_sel <= `BWPS_PIN_SEL_RST;
      interrupt_polarity <= 1'b0;
      strap <= 1'b0;
      boot_req <= 1'b1;
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_mux(addr_i, int_en, pin_sel, {7'h00, interrupt_polarity},
                               {3'h0, strap, 2'h0, sys_state_i}) : 8'h00;
      if (boot_req) begin
        strap <= strap_sync;
        if (strap_sync) begin
          int_en <= `BWPS_INT_EN_RST_STRAP | (int_en & `BWPS_BOOT_EVENT_DISABLE_MASK);
        end
      end
      if (soft_rst) begin
        int_en <= `BWPS_INT_EN_RST | (int_en & `BWPS_BOOT_EVENT_DISABLE_MASK);
        pin_sel <= `BWPS_PIN_SEL_RST;
        interrupt_polarity <= 1'b0;
        boot_req <= 1'b1;
      end else if (deep_pd) begin
        int_en <= `BWPS_INT_EN_RST;
        interrupt_polarity <= wdata_i[`BWPS_BIT_POL];
      end else if (wr_i && addr_i == `BWPS_ADDR_INT_EN) begin
        int_en <= wdata_i;
      end else if (wr_i && addr_i == `BWPS_ADDR_PIN_SEL) begin
        pin_sel <= wdata_i;
      end else if (wr_i && addr_i == `BWPS_ADDR_CTRL) begin
        interrupt_polarity <= wdata_i[`BWPS_BIT_POL];
      end
      if (boot_done && !soft_rst) begin
        boot_req <= 1'b0;
      end
    end
  end

  // Boot sequence
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (boot_done && !soft_rst) begin
          next_state = boot_event_disable ? ST_DONE : ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (!busy) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_IDLE;
    endcase
    if (soft_rst) begin
      next_state = ST_IDLE;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  bwps_pulse_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i((state == ST_IDLE) && (next_state == ST_PULSE)),
    .abort_i(soft_rst),
    .len_i(pulse_len),
    .busy_o(busy)
  );

  // Pin drive: boot pulse wins over awake level on the same pin
  always @* begin
    next_first = other_irq1_i ? interrupt_polarity : !interrupt_polarity;
    next_second = other_irq2_i ? interrupt_polarity : !interrupt_polarity;
    next_first_oe = 1'b1;
    next_second_oe = 1'b1;
    if (awake_en) begin
      if (awake_route) begin
        next_second = awake_level ? interrupt_polarity : !interrupt_polarity;
      end else begin
        next_first = awake_level ? interrupt_polarity : !interrupt_polarity;
      end
    end
    if (strap) begin
      next_second = 1'b1;
      next_second_oe = 1'b0;
    end
    if (boot_active) begin
      if (boot_route) begin
        next_second = pulse_lvl;
        next_second_oe = 1'b1;
      end else begin
        next_first = pulse_lvl;
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      first_interrupt_pin_o <= 1'b1;
      first_interrupt_pin_oe_o <= 1'b0;
      second_interrupt_pin_o <= 1'b1;
      second_interrupt_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      first_interrupt_pin_o <= next_first;
      first_interrupt_pin_oe_o <= next_first_oe;
      second_interrupt_pin_o <= next_second;
      second_interrupt_pin_oe_o <= next_second_oe;
    end
  end
endmodule // bwps_top
`default_nettype wire

// *** bwps_host_model.sv ***
// Host pull-ups seen on both interrupt lines
`timescale 1ns/1ps
`default_nettype none
module bwps_host_model (
  // Device pins
  input wire logic p1_i,
  input wire logic p1_oe_i,
  input wire logic p2_i,
  input wire logic p2_oe_i,
  // Line levels
  output logic line1_o,
  output logic line2_o
);
  // Released line floats up to the pull-up
  assign line1_o = p1_oe_i ? p1_i : 1'b1;
  assign line2_o = p2_oe_i ? p2_i : 1'b1;
endmodule // bwps_host_model
`default_nettype wire

// *** bwps_top_asserts.sv ***
// Checker for boot pulse and awake level on the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module bwps_top_asserts #(
  parameter SHORT_CYC = 4,
  parameter LONG_CYC = 8
) (
  // Clock and device side
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic boot_strap_select_i,
  input wire logic [1:0] sys_state_i,
  input wire logic other_irq1_i,
  input wire logic other_irq2_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Pins
  input wire logic first_interrupt_pin_o,
  input wire logic first_interrupt_pin_oe_o,
  input wire logic second_interrupt_pin_o,
  input wire logic second_interrupt_pin_oe_o
);
  logic [1:0] ie, ps;
  logic pol, pend;
  logic [3:0] qc, bc, ac;
  wire strap = boot_strap_select_i;
  wire boot_wr = wr_i && addr_i == 8'h22 && wdata_i[3] && !wdata_i[1];
  wire bpin = ps[1] ? second_interrupt_pin_o : first_interrupt_pin_o;
  wire wpin = ps[0] ? second_interrupt_pin_o : first_interrupt_pin_o;
  wire low2 = second_interrupt_pin_oe_o && !second_interrupt_pin_o;
  wire act = strap ? low2 : bpin == pol;
  wire [3:0] len = strap ? 4'(LONG_CYC) : 4'(SHORT_CYC);
  wire quiet = !strap && qc == 4'hf && !other_irq1_i && !other_irq2_i;
  always_ff @(posedge sys_clk_i) begin
    ac <= act ? ac + 4'h1 : 4'h0;
    bc <= boot_wr ? 4'h0 : bc + {3'h0, bc != 4'hf};
    qc <= (wr_i || $changed({sys_state_i, strap, other_irq2_i})) ? 4'h0 : qc + {3'h0, qc != 4'hf};
    if (wr_i && addr_i == 8'h20) begin
      ie <= wdata_i[1:0];
    end
    if (wr_i && addr_i == 8'h21) begin
      ps <= wdata_i[1:0];
    end
    // Boot pending until a boot-complete strobe; soft reset re-arms it
    if (boot_wr) begin
      pend <= 1'b0;
    end
    if (wr_i && addr_i == 8'h22) begin
      pol <= wdata_i[0] && !wdata_i[1];
      if (wdata_i[1]) begin
        ps <= 2'h0;
        ie <= ie & 2'h2;
        pend <= 1'b1;
      end else if (wdata_i[2]) begin
        ie <= 2'h0;
      end
    end
    if (rst_i) begin
      {ie, ps, pol} <= 5'h00;
      {qc, bc, ac} <= 12'h000;
      pend <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  chk_read_route: assert property (rd_i && addr_i == 8'h21 |=> rdata_o == {6'h0, ps})
    else $error("pin select read back wrong");
  chk_boot_start: assert property (boot_wr && pend && wdata_i[0] == pol && ie == 2'h0 && !strap
    |-> ##[2:3] (bpin == pol) [*2]) else $error("boot pulse missing");
  chk_boot_len: assert property (ac > 4'h1 && !act && bc != 4'hf
    |-> ac == len || ac == len + 4'h1) else $error("boot pulse length wrong");
  chk_boot_off: assert property (boot_wr && ie == 2'h2 && !strap
    |=> (first_interrupt_pin_o != pol && second_interrupt_pin_o != pol) [*8]) else $error("boot shown");
  chk_strap_drive: assert property (boot_wr && pend && strap && $stable(strap) |-> ##[2:3] low2 [*2])
    else $error("strap boot pulse missing");
  chk_strap_release: assert property (strap && qc == 4'hf && !ie[0] |-> !second_interrupt_pin_oe_o)
    else $error("second pin driven outside boot");
  chk_awake_level: assert property (quiet && ie[0] |-> wpin == (sys_state_i == 2'h1 ? pol : !pol))
    else $error("awake level wrong");
  chk_awake_off: assert property (quiet && !ie[0]
    |-> first_interrupt_pin_o != pol && second_interrupt_pin_o != pol) else $error("awake shown");
  cov_short: cover property (!strap && ac > 4'h1 && !act);
  cov_long: cover property (strap && ac > 4'h1 && !act);
  cov_awake: cover property (quiet && ie[0] && sys_state_i == 2'h1);
endmodule // bwps_top_asserts
bind bwps_top bwps_top_asserts #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_chk (.*);
`default_nettype wire

// *** bwps_top_bench.sv ***
// Self-checking bench for boot pulse and awake pin signaling
`timescale 1ns/1ps
`default_nettype none
module bwps_top_bench;
  logic clk = 0, rst = 1, ce = 1, strap = 0, oi1 = 0, oi2 = 0, wr = 0, rd = 0, en, r, p;
  logic [1:0] st = 2'h0, s;
  logic [7:0] a = 8'h00, wd = 8'h00, rdat;
  logic p1, p1e, p2, p2e, l1, l2;
  int bad_count = 0, checks = 0, n;
  bwps_top #(.SHORT_CYC(4), .LONG_CYC(8)) u_dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .boot_strap_select_i(strap), .sys_state_i(st), .other_irq1_i(oi1), .other_irq2_i(oi2),
    .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .first_interrupt_pin_o(p1), .first_interrupt_pin_oe_o(p1e),
    .second_interrupt_pin_o(p2), .second_interrupt_pin_oe_o(p2e));
  bwps_host_model u_host (.p1_i(p1), .p1_oe_i(p1e), .p2_i(p2), .p2_oe_i(p2e),
    .line1_o(l1), .line2_o(l2));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask
  // Counts cycles the watched line sits at the given level after a boot
  // Soft reset first: a boot strobe only acts once per reset, and it clears routing
  task automatic boot(input logic sel, input logic lvl);
    wreg(8'h22, 8'h02);
    wreg(8'h21, {6'h0, sel, 1'b0});
    wreg(8'h22, {7'h0, lvl});
    wreg(8'h22, {7'h04, lvl});
    n = 0;
    repeat (16) begin
      @(posedge clk);
      #1;
      n += int'((sel ? l2 : l1) === lvl);
    end
  endtask
  function automatic logic [7:0] exp_pins(logic e, logic rt, logic pl, logic [1:0] sv);
    logic v;
    v = (e && sv == 2'h1) ? pl : !pl;
    return rt ? {6'h0, v, !pl} : {6'h0, !pl, v};
  endfunction
  task automatic summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'hdaee));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rreg(8'h20, 8'h00);
    wreg(8'h47, 8'h5a);
    rreg(8'h47, 8'h00);
    for (int i = 0; i < 4; i++) begin
      boot(i[0], i[1]);
      chk({7'h0, n == 4 || n == 5}, 8'h01);
    end
    wreg(8'h20, 8'h02);
    boot(1'b1, 1'b0);
    chk(n[7:0], 8'h00);
    wreg(8'h22, 8'h02);
    rreg(8'h20, 8'h02);
    wreg(8'h22, 8'h04);
    rreg(8'h20, 8'h00);
    repeat (16) @(posedge clk);
    // Other sources stay quiet while the awake line is in use
    // First pass is a fixed corner: awake shown on the first pin, high active
    for (int k = 0; k < 24; k++) begin
      {en, r, p, s} = (k == 0) ? 5'h15 : 5'($urandom);
      wreg(8'h20, {7'h0, en});
      wreg(8'h21, {7'h0, r});
      wreg(8'h22, {7'h0, p});
      st <= s;
      repeat (16) @(posedge clk);
      #1;
      chk({6'h0, l2, l1}, exp_pins(en, r, p, s));
      rreg(8'h21, {7'h0, r});
    end
    wreg(8'h20, 8'h00);
    wreg(8'h22, 8'h00);
    strap <= 1'b1;
    oi2 <= 1'b1;
    repeat (16) @(posedge clk);
    wreg(8'h22, 8'h02);
    wreg(8'h20, 8'h02);
    boot(1'b1, 1'b0);
    chk({7'h0, n == 8 || n == 9}, 8'h01);
    chk({7'h0, l2}, 8'h01);
    summarize();
  end
endmodule // bwps_top_bench
`default_nettype wire
